// ### core/svhcr_pkg.sv
// Register map, field positions and reset values of the serial video control bank
package svhcr_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned NUM_CH = 2;

	// Register offsets
	localparam logic [7:0] OFF_COMMAND   = 8'h00;
	localparam logic [7:0] OFF_DATA_PATH = 8'h01;
	localparam logic [7:0] OFF_FUNCTION  = 8'h02;
	localparam logic [7:0] OFF_LOCK_STAT = 8'h03;
	localparam logic [7:0] OFF_ORIGIN    = 8'h05;
	localparam logic [7:0] OFF_SWAP_CFG  = 8'h0f;
	localparam logic [7:0] OFF_PER_CHANNEL_ENABLE_BITS = 8'h10;
	localparam logic [7:0] OFF_DIRECTION = 8'h12;
	localparam logic [7:0] OFF_EDGE      = 8'h13;
	localparam logic [7:0] OFF_FRAMING   = 8'h14;
	localparam logic [7:0] OFF_UNDERFLOW = 8'h18;
	localparam logic [7:0] OFF_OVERFLOW  = 8'h1a;
	localparam logic [7:0] OFF_INT_STAT  = 8'h20;
	localparam logic [7:0] OFF_INT_MASK  = 8'h21;
	localparam logic [7:0] OFF_RSVD_LO   = 8'h80;
	localparam logic [7:0] OFF_RSVD_HI   = 8'h81;

	// Field positions
	localparam int unsigned BIT_CMD_EN    = 3;
	localparam int unsigned BIT_LOCKED    = 0;
	localparam int unsigned BIT_HALF_SWAP = 3;
	localparam int unsigned BIT_BYTE_SWAP = 0;
	localparam int unsigned CH_RX_BASE    = 0;
	localparam int unsigned CH_TX_BASE    = 2;
	localparam int unsigned INT_UNDER_LSB = 0;
	localparam int unsigned INT_OVER_LSB  = 2;

	// Legacy register slots (stored, no effect)
	localparam int unsigned LEG_DATA_PATH = 0;
	localparam int unsigned LEG_FUNCTION  = 1;
	localparam int unsigned LEG_DIRECTION = 2;
	localparam int unsigned LEG_EDGE      = 3;
	localparam int unsigned LEG_FRAMING   = 4;
	localparam int unsigned NUM_LEGACY    = 5;

	// Reset values
	localparam logic        RST_CMD_EN   = 1'h0;
	localparam logic [1:0]  RST_SWAP     = 2'h0;
	localparam logic [3:0]  RST_CH_EN    = 4'h0;
	localparam logic [7:0]  RST_LEGACY   = 8'h00;
	localparam logic [3:0]  RST_INT_MASK = 4'h0;
	localparam logic [15:0] READ_ZERO    = 16'h0000;

	// Origin code: arbitrary neutral value
	localparam logic [7:0] ORIGIN_DEFAULT = 8'h5a;
endpackage

// ### core/svhcr_regs.sv
// Control and status register bank with swap datapath and channel gating
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - A channel moves DMA data only while the global enable and its own channel enable are set.
// - With the global enable clear all channels are held in reset, FIFOs flushed, flags cleared.
// - Lock status bit zero reads one only while the host-side transfer clock reports lock.
// - A read-only byte returns the code of whoever made the loaded configuration.
// - The half-word exchange bit swaps the two 16-bit halves of each 32-bit word.
// - The byte-pair exchange bit swaps bytes within each half, giving order 1, 0, 3, 2.
// - With both exchange bits set the bytes of each word come out fully reversed.
// - Channel enable bits zero and one gate receive data of channels zero and one.
// - Channel enable bits two and three gate transmit data of channels zero and one.
// - A cleared channel enable bit holds that path in reset until set again.
// - Addresses 0x80 and 0x81 are reserved and do nothing.
// - Legacy registers accept accesses but never affect the channels.
// - A transmit underflow sets that channel's flag and repeats the last valid byte.
// - A receive overflow sets that channel's flag and drops data while it lasts.
module svhcr_regs #(
	parameter logic [7:0] ORIGIN_CODE = svhcr_pkg::ORIGIN_DEFAULT
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output var  logic [15:0] regRdData,
	output var  logic        irq,
	input  wire logic        hostSideClockLocked,
	input  wire logic [31:0] wordIn,
	input  wire logic        wordInValid,
	output var  logic [31:0] wordOut,
	output var  logic        wordOutValid,
	input  wire logic [1:0]  txFifoValid,
	input  wire logic [15:0] txFifoByte,
	input  wire logic [1:0]  txSlot,
	output var  logic [15:0] txLineByte,
	output var  logic [1:0]  txLineValid,
	input  wire logic [1:0]  rxByteValid,
	input  wire logic [15:0] rxByte,
	input  wire logic [1:0]  rxFifoFull,
	output var  logic [1:0]  rxFifoWrite,
	output var  logic [15:0] rxFifoByte,
	output var  logic [1:0]  rxChanRun,
	output var  logic [1:0]  txChanRun,
	output var  logic [1:0]  rxChanReset,
	output var  logic [1:0]  txChanReset,
	output var  logic        fifoFlush
);
	typedef struct packed {
		logic                                   cmdEn;
		logic [1:0]                             swapCfg;
		logic [3:0]                             chEn;
		logic [svhcr_pkg::NUM_LEGACY-1:0][7:0]  legacy;
		logic [1:0]                             underFlag;
		logic [1:0]                             overFlag;
		logic [3:0]                             intStat;
		logic [3:0]                             intMask;
		logic [15:0]                            rdData;
		logic                                   irq;
		logic [31:0]                            wordOut;
		logic                                   wordOutValid;
		logic [1:0][7:0]                        txHold;
		logic [1:0]                             txValid;
		logic [1:0]                             rxWrite;
		logic [1:0][7:0]                        rxData;
		logic [1:0]                             rxRun;
		logic [1:0]                             txRun;
		logic [1:0]                             rxRst;
		logic [1:0]                             txRst;
		logic                                   flush;
	} svhcr_state_t;

	svhcr_state_t st_r;
	svhcr_state_t st_nxt;

	// Whole state is one record; this process computes the next copy
	always_comb begin
		logic [31:0] w;
		logic [1:0]  rxRunNow;
		logic [1:0]  txRunNow;
		logic [3:0]  events;
		logic [15:0] rd;
		st_nxt = st_r;
		w = wordIn;
		rxRunNow = '0;
		txRunNow = '0;
		events = '0;
		rd = svhcr_pkg::READ_ZERO;

		// Register writes; unmapped and reserved addresses fall through
		if (regWrite) begin
			if (regAddr == svhcr_pkg::OFF_COMMAND) begin
				st_nxt.cmdEn = regWrData[svhcr_pkg::BIT_CMD_EN];
			end else if (regAddr == svhcr_pkg::OFF_SWAP_CFG) begin
				st_nxt.swapCfg = {regWrData[svhcr_pkg::BIT_HALF_SWAP],
					regWrData[svhcr_pkg::BIT_BYTE_SWAP]};
			end else if (regAddr == svhcr_pkg::OFF_PER_CHANNEL_ENABLE_BITS) begin
				st_nxt.chEn = regWrData[3:0];
			end else if (regAddr == svhcr_pkg::OFF_DATA_PATH) begin
				st_nxt.legacy[svhcr_pkg::LEG_DATA_PATH] = regWrData[7:0];
			end else if (regAddr == svhcr_pkg::OFF_FUNCTION) begin
				st_nxt.legacy[svhcr_pkg::LEG_FUNCTION] = regWrData[7:0];
			end else if (regAddr == svhcr_pkg::OFF_DIRECTION) begin
				st_nxt.legacy[svhcr_pkg::LEG_DIRECTION] = regWrData[7:0];
			end else if (regAddr == svhcr_pkg::OFF_EDGE) begin
				st_nxt.legacy[svhcr_pkg::LEG_EDGE] = regWrData[7:0];
			end else if (regAddr == svhcr_pkg::OFF_FRAMING) begin
				st_nxt.legacy[svhcr_pkg::LEG_FRAMING] = regWrData[7:0];
			end else if (regAddr == svhcr_pkg::OFF_INT_MASK) begin
				st_nxt.intMask = regWrData[3:0];
			end
		end

		// Channel run decisions use the freshly written enables
		for (int c = 0; c < svhcr_pkg::NUM_CH; c++) begin
			rxRunNow[c] = st_nxt.cmdEn & st_nxt.chEn[svhcr_pkg::CH_RX_BASE + c];
			txRunNow[c] = st_nxt.cmdEn & st_nxt.chEn[svhcr_pkg::CH_TX_BASE + c];
		end
		st_nxt.rxRun = rxRunNow;
		st_nxt.txRun = txRunNow;
		// Reset lines kept as flops of their own, so no inverter sits on an output
		st_nxt.rxRst = ~rxRunNow;
		st_nxt.txRst = ~txRunNow;
		st_nxt.flush = ~st_nxt.cmdEn;

		// Per-channel datapaths; a path out of run is held idle
		for (int c = 0; c < svhcr_pkg::NUM_CH; c++) begin
			st_nxt.txValid[c] = 1'b0;
			st_nxt.rxWrite[c] = 1'b0;
			if (!txRunNow[c]) begin
				st_nxt.txHold[c] = '0;
				st_nxt.underFlag[c] = 1'b0;
			end else if (txSlot[c]) begin
				st_nxt.txValid[c] = 1'b1;
				if (txFifoValid[c]) begin
					st_nxt.txHold[c] = txFifoByte[c*8 +: 8];
				end else begin
					// Old byte stays in txHold and is sent again
					st_nxt.underFlag[c] = 1'b1;
					events[svhcr_pkg::INT_UNDER_LSB + c] = 1'b1;
				end
			end
			if (!rxRunNow[c]) begin
				st_nxt.overFlag[c] = 1'b0;
			end else if (rxByteValid[c]) begin
				if (rxFifoFull[c]) begin
					// Byte is discarded, the FIFO is not touched
					st_nxt.overFlag[c] = 1'b1;
					events[svhcr_pkg::INT_OVER_LSB + c] = 1'b1;
				end else begin
					st_nxt.rxWrite[c] = 1'b1;
					st_nxt.rxData[c] = rxByte[c*8 +: 8];
				end
			end
		end

		// Word swapping, byte 0 is bits 7:0
		case (st_r.swapCfg)
			2'h2: w = {wordIn[15:0], wordIn[31:16]};
			2'h1: w = {wordIn[23:16], wordIn[31:24], wordIn[7:0], wordIn[15:8]};
			2'h3: w = {wordIn[7:0], wordIn[15:8], wordIn[23:16], wordIn[31:24]};
			default: w = wordIn;
		endcase
		st_nxt.wordOut = w;
		st_nxt.wordOutValid = wordInValid;

		// Sticky interrupt bits: a new event beats a same-cycle clear
		if (regWrite && regAddr == svhcr_pkg::OFF_INT_STAT) begin
			st_nxt.intStat = st_r.intStat & ~regWrData[3:0];
		end
		st_nxt.intStat = st_nxt.intStat | events;
		st_nxt.irq = |(st_nxt.intStat & st_nxt.intMask);

		// Read mux; answer lands in the cycle after the strobe only
		if (regRead) begin
			if (regAddr == svhcr_pkg::OFF_COMMAND) begin
				rd[svhcr_pkg::BIT_CMD_EN] = st_r.cmdEn;
			end else if (regAddr == svhcr_pkg::OFF_LOCK_STAT) begin
				rd[svhcr_pkg::BIT_LOCKED] = hostSideClockLocked;
			end else if (regAddr == svhcr_pkg::OFF_ORIGIN) begin
				rd[7:0] = ORIGIN_CODE;
			end else if (regAddr == svhcr_pkg::OFF_SWAP_CFG) begin
				rd[svhcr_pkg::BIT_HALF_SWAP] = st_r.swapCfg[1];
				rd[svhcr_pkg::BIT_BYTE_SWAP] = st_r.swapCfg[0];
			end else if (regAddr == svhcr_pkg::OFF_PER_CHANNEL_ENABLE_BITS) begin
				rd[3:0] = st_r.chEn;
			end else if (regAddr == svhcr_pkg::OFF_DATA_PATH) begin
				rd[7:0] = st_r.legacy[svhcr_pkg::LEG_DATA_PATH];
			end else if (regAddr == svhcr_pkg::OFF_FUNCTION) begin
				rd[7:0] = st_r.legacy[svhcr_pkg::LEG_FUNCTION];
			end else if (regAddr == svhcr_pkg::OFF_DIRECTION) begin
				rd[7:0] = st_r.legacy[svhcr_pkg::LEG_DIRECTION];
			end else if (regAddr == svhcr_pkg::OFF_EDGE) begin
				rd[7:0] = st_r.legacy[svhcr_pkg::LEG_EDGE];
			end else if (regAddr == svhcr_pkg::OFF_FRAMING) begin
				rd[7:0] = st_r.legacy[svhcr_pkg::LEG_FRAMING];
			end else if (regAddr == svhcr_pkg::OFF_UNDERFLOW) begin
				rd[1:0] = st_r.underFlag;
			end else if (regAddr == svhcr_pkg::OFF_OVERFLOW) begin
				rd[1:0] = st_r.overFlag;
			end else if (regAddr == svhcr_pkg::OFF_INT_STAT) begin
				rd[3:0] = st_r.intStat;
			end else if (regAddr == svhcr_pkg::OFF_INT_MASK) begin
				rd[3:0] = st_r.intMask;
			end else if (regAddr == svhcr_pkg::OFF_RSVD_LO || regAddr == svhcr_pkg::OFF_RSVD_HI) begin
				rd = svhcr_pkg::READ_ZERO;
			end
		end
		st_nxt.rdData = rd;
	end

	// State register; async reset loads constants only
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
			st_r.cmdEn <= svhcr_pkg::RST_CMD_EN;
			st_r.swapCfg <= svhcr_pkg::RST_SWAP;
			st_r.chEn <= svhcr_pkg::RST_CH_EN;
			st_r.intMask <= svhcr_pkg::RST_INT_MASK;
			st_r.rxRst <= 2'h3;
			st_r.txRst <= 2'h3;
			st_r.flush <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state flip-flops
	assign regRdData    = st_r.rdData;
	assign irq          = st_r.irq;
	assign wordOut      = st_r.wordOut;
	assign wordOutValid = st_r.wordOutValid;
	assign txLineByte   = st_r.txHold;
	assign txLineValid  = st_r.txValid;
	assign rxFifoWrite  = st_r.rxWrite;
	assign rxFifoByte   = st_r.rxData;
	assign rxChanRun    = st_r.rxRun;
	assign txChanRun    = st_r.txRun;
	assign rxChanReset  = st_r.rxRst;
	assign txChanReset  = st_r.txRst;
	assign fifoFlush    = st_r.flush;
endmodule

`default_nettype wire

// ### testbench/svhcr_dma_model.sv
// Behavioural DMA side: feeds transmit FIFOs and reports receive FIFO fill
`timescale 1ns/1ps
`default_nettype none
module svhcr_dma_model (
	input  wire logic        txStarve,
	input  wire logic        rxStall,
	output logic [1:0]  txFifoValid,
	output logic [15:0] txFifoByte,
	output logic [1:0]  rxFifoFull
);
	// Starved FIFOs show the inverse byte, so a stale value cannot pass
	assign txFifoValid = txStarve ? 2'h0 : 2'h3;
	assign txFifoByte  = txStarve ? 16'h3c5a : 16'hc3a5;
	// Stall reports full at once, the slow end of the far side
	assign rxFifoFull = rxStall ? 2'h3 : 2'h0;
endmodule
`default_nettype wire

// ### testbench/svhcr_regs_sva.sv
// Port-level checker for the control register bank
`timescale 1ns/1ps
`default_nettype none
module svhcr_regs_sva #(
	parameter logic [7:0] ORIGIN_CODE = 8'h5a
) (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic [7:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [15:0] regRdData,
	input wire logic        hostSideClockLocked,
	input wire logic [31:0] wordIn,
	input wire logic        wordInValid,
	input wire logic [31:0] wordOut,
	input wire logic [1:0]  rxByteValid,
	input wire logic [1:0]  rxFifoFull,
	input wire logic [1:0]  rxFifoWrite,
	input wire logic [1:0]  rxChanRun,
	input wire logic [1:0]  txChanRun,
	input wire logic [1:0]  rxChanReset,
	input wire logic [1:0]  txChanReset,
	input wire logic        fifoFlush
);
	logic [1:0] swapCfg_r;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Shadow of the two swap bits, the only state kept here
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			swapCfg_r <= 2'h0;
		else if (regWrite && regAddr == 8'h0f)
			swapCfg_r <= {regWrData[3], regWrData[0]};
	end
	a_flush_after_cmd: assert property (regWrite && regAddr == 8'h00 |=>
		fifoFlush == !$past(regWrData[3])) else $error("flush wrong after command write");
	a_run_needs_cmd: assert property (fifoFlush |-> rxChanRun == 2'h0 && txChanRun == 2'h0)
		else $error("channel running while flushed");
	a_rx_reset_inverse: assert property (rxChanReset == ~rxChanRun)
		else $error("rx reset not inverse of run");
	a_tx_reset_inverse: assert property (txChanReset == ~txChanRun)
		else $error("tx reset not inverse of run");
	a_full_reverse: assert property (wordInValid && swapCfg_r == 2'h3 |=> wordOut ==
		{$past(wordIn[7:0]), $past(wordIn[15:8]), $past(wordIn[23:16]), $past(wordIn[31:24])})
		else $error("word not fully reversed");
	a_rx_full_drop: assert property (rxByteValid[0] && rxFifoFull[0] |=> !rxFifoWrite[0])
		else $error("byte written into full FIFO");
	a_lock_read_live: assert property (regRead && regAddr == 8'h03 |=>
		regRdData == {15'h0000, $past(hostSideClockLocked)}) else $error("lock bit wrong");
	a_origin_read: assert property (regRead && regAddr == 8'h05 |=>
		regRdData == {8'h00, ORIGIN_CODE}) else $error("origin code wrong");
	a_reserved_zero: assert property (regRead && regAddr[7:1] == 7'h40 |=>
		regRdData == 16'h0000) else $error("reserved address read nonzero");
endmodule
`default_nettype wire

// ### testbench/test_svhcr_regs.sv
// Self-checking bench for the serial video control register bank
`timescale 1ns/1ps
`default_nettype none
module test_svhcr_regs;
	logic        ref_clk, reset, regWrite, regRead, irq, hostSideClockLocked;
	logic        wordInValid, wordOutValid, fifoFlush, txStarve, rxStall;
	logic [7:0]  regAddr;
	logic [15:0] regWrData, regRdData, txFifoByte, txLineByte, rxByte, rxFifoByte;
	logic [31:0] wordIn, wordOut;
	logic [1:0]  txFifoValid, txSlot, txLineValid, rxByteValid, rxFifoFull, rxFifoWrite;
	logic [1:0]  rxChanRun, txChanRun, rxChanReset, txChanReset;
	logic [31:0] swapExp [4] = '{32'h11223344, 32'h22114433, 32'h33441122, 32'h44332211};
	int          n_mismatch = 0;
	int          compares = 0;
	svhcr_regs svhcr_regs_inst (.ref_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead,
		.regRdData, .irq, .hostSideClockLocked, .wordIn, .wordInValid, .wordOut, .wordOutValid,
		.txFifoValid, .txFifoByte, .txSlot, .txLineByte, .txLineValid, .rxByteValid, .rxByte,
		.rxFifoFull, .rxFifoWrite, .rxFifoByte, .rxChanRun, .txChanRun, .rxChanReset,
		.txChanReset, .fifoFlush);
	svhcr_dma_model svhcr_dma_model_inst (.txStarve, .rxStall, .txFifoValid, .txFifoByte,
		.rxFifoFull);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Bus cycles: one-cycle strobes, read data sampled mid-cycle after
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regWrite  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		@(negedge ref_clk);
		check(regRdData, e);
	endtask
	task automatic txPulse(input logic starve, input logic [7:0] e);
		@(posedge ref_clk);
		txSlot   <= 2'h1;
		txStarve <= starve;
		@(posedge ref_clk);
		txSlot <= 2'h0;
		@(negedge ref_clk);
		check({txLineValid, txLineByte[7:0]}, {2'h1, e});
	endtask
	task automatic rxPulse(input logic stall, input logic [1:0] e);
		@(posedge ref_clk);
		rxByteValid <= 2'h3;
		rxByte      <= 16'h7e81;
		rxStall     <= stall;
		@(posedge ref_clk);
		rxByteValid <= 2'h0;
		@(negedge ref_clk);
		check(rxFifoWrite, e);
	endtask
	task automatic final_report();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Clock at 40 MHz
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Watchdog far beyond the hundred or so cycles the tests need
	initial begin
		repeat (4000) @(posedge ref_clk);
		n_mismatch++;
		final_report();
	end
	// Main sequence
	initial begin
		reset = 1'b1;
		{regAddr, regWrData, regWrite, regRead, wordIn, wordInValid} = '0;
		{txSlot, rxByteValid, rxByte, txStarve, rxStall, hostSideClockLocked} = '0;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		check({fifoFlush, rxChanReset, txChanReset}, 5'h1f);
		wr(8'h03, 16'hffff);
		hostSideClockLocked <= 1'b1;
		rdc(8'h03, 16'h0001);
		wr(8'h05, 16'h00ff);
		hostSideClockLocked <= 1'b0;
		rdc(8'h03, 16'h0000);
		rdc(8'h05, 16'h005a);
		wr(8'h80, 16'hffff);
		rdc(8'h80, 16'h0000);
		rdc(8'h81, 16'h0000);
		wr(8'h01, 16'hffff);
		rdc(8'h01, 16'h00ff);
		wr(8'h00, 16'hffff);
		rdc(8'h00, 16'h0008);
		check({rxChanRun, txChanRun, fifoFlush}, 5'h00);
		wr(8'h10, 16'hfff5);
		rdc(8'h10, 16'h0005);
		check({rxChanRun, txChanRun, rxChanReset, txChanReset}, 8'h5a);
		// Every swap setting on the same word
		for (int i = 0; i < 4; i++) begin
			wr(8'h0f, {12'h000, i[1], 2'h0, i[0]});
			wordIn      <= 32'h11223344;
			wordInValid <= 1'b1;
			@(posedge ref_clk);
			wordInValid <= 1'b0;
			@(negedge ref_clk);
			check({wordOutValid, wordOut}, {1'b1, swapExp[i]});
		end
		// Fresh byte, then a starved slot must repeat it, not the stale bus
		txPulse(1'b0, 8'ha5);
		txPulse(1'b1, 8'ha5);
		rdc(8'h18, 16'h0001);
		check(irq, 1'b0);
		wr(8'h21, 16'h0001);
		repeat (2) @(negedge ref_clk);
		check(irq, 1'b1);
		wr(8'h20, 16'h0001);
		repeat (2) @(negedge ref_clk);
		check(irq, 1'b0);
		rxPulse(1'b0, 2'h1);
		check(rxFifoByte[7:0], 8'h81);
		rxPulse(1'b1, 2'h0);
		rdc(8'h1a, 16'h0001);
		wr(8'h10, 16'h0004);
		rdc(8'h1a, 16'h0000);
		rdc(8'h18, 16'h0001);
		wr(8'h00, 16'h0000);
		@(negedge ref_clk);
		check({fifoFlush, rxChanRun, txChanRun}, 5'h10);
		rdc(8'h18, 16'h0000);
		final_report();
	end
endmodule
bind svhcr_regs svhcr_regs_sva #(.ORIGIN_CODE(ORIGIN_CODE)) svhcr_regs_sva_inst (.ref_clk,
	.reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .hostSideClockLocked,
	.wordIn, .wordInValid, .wordOut, .rxByteValid, .rxFifoFull, .rxFifoWrite, .rxChanRun,
	.txChanRun, .rxChanReset, .txChanReset, .fifoFlush);
`default_nettype wire
